// File: design/asfm_pkg.sv
/*
  package for the accelerometer sample queue: register offsets, field
  layout, mode encodings, timing constants and carrier structs.
  assumes a register front end that delivers byte accesses by address.
*/
package asfm_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ASFM_OFS_X_LO   = 8'h32;
  localparam logic [7:0] ASFM_OFS_Z_HI   = 8'h37;
  localparam logic [7:0] ASFM_OFS_CTRL   = 8'h38;
  localparam logic [7:0] ASFM_OFS_STATUS = 8'h39;

  // ----------------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------------
  localparam int         ASFM_MODE_MSB   = 7;
  localparam int         ASFM_MODE_LSB   = 6;
  localparam int         ASFM_TRIGSEL_BIT = 5;
  localparam int         ASFM_THR_MSB    = 4;
  localparam int         ASFM_TRIGSEEN_BIT = 7;
  localparam logic [7:0] ASFM_CTRL_RST   = 8'h00;
  localparam int         ASFM_DEPTH      = 32;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int ASFM_CLK_MHZ      = 100;
  localparam int ASFM_TRIG_SETTLE_US = 5;
  localparam int ASFM_TRIG_SETTLE_CYC = ASFM_TRIG_SETTLE_US * ASFM_CLK_MHZ;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ASFM_MODE_BYPASS  = 2'h0,
    ASFM_MODE_FILL    = 2'h1,
    ASFM_MODE_STREAM  = 2'h2,
    ASFM_MODE_TRIGGER = 2'h3
  } asfm_mode_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } asfm_sample_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } asfm_regreq_t;

endpackage

// File: design/asfm_top.sv
/*
  sample queue between the measurement path and the output data
  registers, with bypass, fill-and-stop, stream and trigger modes.
  assumes a serial front end presenting byte register accesses with a
  read strobe, and a chip-select level; one clock, synchronous reset.
*/
// Overview of operation
// - two-bit mode field at 0x38 selects bypass, fill, stream or trigger
// - bypass keeps queue empty; samples go straight to data registers
// - fill mode stores until 32 held, then only while not full
// - stream mode keeps newest 32, dropping oldest when full
// - watermark flag sets when count equals samples threshold
// - watermark stays set until count drops below threshold
// - measuring and other detection continue after queue stops
// - trigger event raises chosen irq pin and trigger-seen status bit
// - after trigger keep last n samples, then behave as fill mode
// - further triggers ignored until bypass then trigger rewritten
// - selecting bypass clears all stored samples
// - each queue read moves oldest sample into data registers
// - single-byte read loses remaining bytes of that sample
// - readback ends on address passing 0x37 to 0x38 or cs high
// - threshold is five low bits of control; watermark self-clears
// - overrun sets when a sample arrives while full, or in bypass when unread sample replaced
// - overrun clears when the contents are read
`timescale 1ns/100ps
module asfm_top
  import asfm_pkg::*;
#(
  parameter int DEPTH = ASFM_DEPTH,
  parameter int AW    = 6
) (
  input  wire logic         core_clk_in,
  input  wire logic         rstn_in,
  input  wire logic         clk_en_in,
  input  wire logic         measure_in,
  input  wire logic         odr_tick_in,
  input  wire asfm_sample_t sample_in,
  input  wire logic         trigger_evt_in,
  input  wire asfm_regreq_t req_in,
  input  wire logic         cs_high_in,
  output logic [7:0]        rdata_out,
  output logic              watermark_out,
  output logic              overrun_out,
  output logic              irq_pin_a_out,
  output logic              irq_pin_b_out
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  asfm_sample_t mem [DEPTH];
  logic [7:0]   ctrl_reg;
  logic [4:0]   rd_ptr_reg;
  logic [4:0]   wr_ptr_reg;
  logic [AW-1:0] count_reg;
  asfm_sample_t out_reg;
  logic         out_unread_reg;
  logic         in_burst_reg;
  logic         trig_seen_reg;
  logic         armed_reg;
  logic [7:0]   rdata_reg;
  logic         wm_reg;
  logic         ovr_reg;
  logic         irq_a_reg;
  logic         irq_b_reg;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire asfm_mode_t mode     =
      asfm_mode_t'(ctrl_reg[ASFM_MODE_MSB:ASFM_MODE_LSB]);
  wire [4:0]  thr           = ctrl_reg[ASFM_THR_MSB:0];
  wire        bypass        = (mode == ASFM_MODE_BYPASS);
  wire        full          = (count_reg == AW'(DEPTH));
  wire        empty         = (count_reg == '0);
  wire        data_addr     = (req_in.addr >= ASFM_OFS_X_LO) &&
                              (req_in.addr <= ASFM_OFS_Z_HI);
  wire        data_rd       = req_in.rd && data_addr;
  wire        ctrl_wr       = req_in.wr && (req_in.addr == ASFM_OFS_CTRL);
  // readback finishes on leaving the data block or on cs high
  wire        burst_end     = in_burst_reg &&
                              (cs_high_in || (req_in.rd && !data_addr));
  // first data byte of a burst latches a fresh sample; a lone byte read
  // therefore discards the rest of that sample
  wire        pop           = !bypass && data_rd && !in_burst_reg &&
                              !empty;
  wire        new_sample    = measure_in && odr_tick_in;
  wire        keep_room     = (mode == ASFM_MODE_STREAM) ||
                              (mode == ASFM_MODE_TRIGGER && !trig_seen_reg);
  wire        push          = new_sample && !bypass &&
                              (!full || keep_room);
  wire        drop_old      = push && full;
  wire        trig_hit      = (mode == ASFM_MODE_TRIGGER) && armed_reg &&
                              !trig_seen_reg && trigger_evt_in;
  // on trigger keep only the newest thr pre-trigger samples
  wire [AW-1:0] keep_n      =
      (count_reg > AW'(thr)) ? AW'(thr) : count_reg;
  wire [4:0]  trim_skip     = 5'(count_reg - keep_n);
  wire [AW-1:0] count_next  =
      trig_hit ? keep_n + AW'(push) :
      count_reg + AW'(push && !drop_old) - AW'(pop);
  wire [4:0]  rd_ptr_next   =
      trig_hit ? 5'(rd_ptr_reg + trim_skip) :
      5'(rd_ptr_reg + 5'(pop) + 5'(drop_old));
  wire        new_mode_byp  = ctrl_wr &&
      (req_in.wdata[ASFM_MODE_MSB:ASFM_MODE_LSB] == 2'(ASFM_MODE_BYPASS));
  wire        wm_next       = (count_next >= AW'(thr));
  wire [7:0]  status_byte   = {trig_seen_reg, 1'b0, count_reg[5:0]};
  wire [2:0]  byte_sel      = 3'(req_in.addr - ASFM_OFS_X_LO);
  wire [47:0] out_bytes     = {out_reg.z, out_reg.y, out_reg.x};
  wire [7:0]  data_byte     = out_bytes[8*byte_sel +: 8];

  // ----------------------------------------------------------------------
  // queue storage and pointers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (clk_en_in && push) begin
      mem[wr_ptr_reg] <= sample_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      ctrl_reg   <= ASFM_CTRL_RST;
      rd_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (clk_en_in) begin
      if (ctrl_wr) begin
        ctrl_reg <= req_in.wdata;
      end
      if (bypass || new_mode_byp) begin
        rd_ptr_reg <= '0;
        wr_ptr_reg <= '0;
        count_reg  <= '0;
      end else begin
        rd_ptr_reg <= rd_ptr_next;
        wr_ptr_reg <= 5'(wr_ptr_reg + 5'(push));
        count_reg  <= count_next;
      end
    end
  end

  // ----------------------------------------------------------------------
  // data registers, burst tracking, trigger arming
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      out_reg        <= '0;
      out_unread_reg <= 1'b0;
      in_burst_reg   <= 1'b0;
      trig_seen_reg  <= 1'b0;
      armed_reg      <= 1'b0;
    end else if (clk_en_in) begin
      if (bypass && new_sample) begin
        out_reg <= sample_in;
      end else if (pop) begin
        out_reg <= mem[rd_ptr_reg];
      end
      if (bypass && new_sample) begin
        out_unread_reg <= 1'b1;
      end else if (data_rd) begin
        out_unread_reg <= 1'b0;
      end
      if (burst_end) begin
        in_burst_reg <= 1'b0;
      end else if (data_rd) begin
        in_burst_reg <= 1'b1;
      end
      if (bypass) begin
        trig_seen_reg <= 1'b0;
        armed_reg     <= 1'b1;
      end else if (trig_hit) begin
        trig_seen_reg <= 1'b1;
        armed_reg     <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // flags, irq pins and read data
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      rdata_reg <= '0;
      wm_reg    <= 1'b0;
      ovr_reg   <= 1'b0;
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
    end else if (clk_en_in) begin
      wm_reg <= !bypass && !new_mode_byp && wm_next;
      if ((bypass && new_sample && out_unread_reg) ||
          (!bypass && full && new_sample)) begin
        ovr_reg <= 1'b1;
      end else if (data_rd) begin
        ovr_reg <= 1'b0;
      end
      irq_a_reg <= trig_seen_reg && !ctrl_reg[ASFM_TRIGSEL_BIT];
      irq_b_reg <= trig_seen_reg &&  ctrl_reg[ASFM_TRIGSEL_BIT];
      if (req_in.rd) begin
        rdata_reg <= data_addr ? (pop ? 8'h00 : data_byte) :
                     (req_in.addr == ASFM_OFS_CTRL)   ? ctrl_reg :
                     (req_in.addr == ASFM_OFS_STATUS) ? status_byte :
                     8'h00;
      end
    end
  end

  assign rdata_out     = rdata_reg;
  assign watermark_out = wm_reg;
  assign overrun_out   = ovr_reg;
  assign irq_pin_a_out = irq_a_reg;
  assign irq_pin_b_out = irq_b_reg;

endmodule // asfm_top

// File: dv/asfm_checker.sv
/* checker: port assertions for the sample queue.
   assumes one clock and clk_en_in held high. */
`timescale 1ns/100ps
module asfm_checker
  import asfm_pkg::*;
(
  input wire logic         core_clk_in,
  input wire logic         rstn_in,
  input wire logic         measure_in,
  input wire logic         odr_tick_in,
  input wire logic         trigger_evt_in,
  input wire asfm_regreq_t req_in,
  input wire logic [7:0]   rdata_out,
  input wire logic         watermark_out,
  input wire logic         overrun_out,
  input wire logic         irq_pin_a_out,
  input wire logic         irq_pin_b_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  wire logic irq  = irq_pin_a_out | irq_pin_b_out;
  wire logic tick = odr_tick_in & measure_in;
  wire logic drd  = req_in.rd & (req_in.addr >= ASFM_OFS_X_LO)
                    & (req_in.addr <= ASFM_OFS_Z_HI);
  wire logic cwr  = req_in.wr & (req_in.addr == ASFM_OFS_CTRL);
  sequence s_drain;
    overrun_out && drd && !tick;
  endsequence
  a_irq_one_pin: assert property (!(irq_pin_a_out && irq_pin_b_out))
    else $error("both irq pins high");
  a_irq_cause: assert property ($rose(irq) |-> $past(trigger_evt_in, 2))
    else $error("irq without trigger");
  a_irq_holds: assert property (irq && !cwr && !$past(cwr)
    && !$past(cwr, 2) |=> irq)
    else $error("irq dropped without rearm");
  a_ovr_clear: assert property (s_drain |=> !overrun_out)
    else $error("overrun kept after read");
  a_ovr_cause: assert property ($rose(overrun_out) |-> $past(tick))
    else $error("overrun without sample");
  a_wm_cause: assert property ($rose(watermark_out)
    |-> $past(tick || cwr) || $past(cwr, 2))
    else $error("watermark rose without cause");
  a_wm_fall: assert property ($fell(watermark_out)
    |-> $past(drd || cwr) || $past(cwr, 2))
    else $error("watermark fell without read");
  a_rdata_holds: assert property (!req_in.rd |=> $stable(rdata_out))
    else $error("read data moved without read");
endmodule // asfm_checker

// File: dv/asfm_host_model.sv
/* host model: byte register requests and chip select.
   assumes requests are taken on the rising clock edge. */
`timescale 1ns/100ps
module asfm_host_model
  import asfm_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic [7:0] rdata_in,
  output asfm_regreq_t    req_out,
  output logic            cs_high_out
);
  initial begin
    req_out = '0;
    cs_high_out = 1'b1;
  end
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q);
    @(posedge core_clk_in);
    cs_high_out <= 1'b0;
    req_out <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge core_clk_in);
    req_out <= '0;
    #1 q = rdata_in;
  endtask
  // release chip select, then keep the readback gap
  task automatic close();
    @(posedge core_clk_in);
    cs_high_out <= 1'b1;
    repeat (ASFM_TRIG_SETTLE_CYC) @(posedge core_clk_in);
  endtask
endmodule // asfm_host_model

// File: dv/asfm_tb_top.sv
/* testbench: fill, stream and trigger runs through byte reads.
   assumes the host model and checker beside it. */
`timescale 1ns/100ps
module asfm_tb_top
  import asfm_pkg::*;
;
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic measure_in = 1'b1;
  logic odr_tick_in = 1'b0;
  logic trigger_evt_in = 1'b0;
  logic clk_en_in = 1'b1;
  asfm_sample_t sample_in = '0;
  asfm_regreq_t req;
  logic cs_high;
  logic [7:0] rdata_out, q;
  logic watermark_out, overrun_out, irq_pin_a_out, irq_pin_b_out;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  always #5 core_clk_in = ~core_clk_in;
  asfm_top u_dut (.core_clk_in, .rstn_in, .clk_en_in, .measure_in,
    .odr_tick_in, .sample_in, .trigger_evt_in, .req_in(req),
    .cs_high_in(cs_high), .rdata_out, .watermark_out, .overrun_out,
    .irq_pin_a_out, .irq_pin_b_out);
  asfm_host_model u_host (.core_clk_in, .rdata_in(rdata_out),
    .req_out(req), .cs_high_out(cs_high));
  function automatic asfm_sample_t smp(input int i);
    return '{16'h1000 + 16'(i), 16'h2000 + 16'(i), 16'h3000 + 16'(i)};
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic push(input int n, input int b);
    for (int k = 0; k < n; k++) begin
      @(posedge core_clk_in);
      odr_tick_in <= 1'b1;
      sample_in <= smp(b + k);
      @(posedge core_clk_in);
      odr_tick_in <= 1'b0;
    end
    repeat (2) @(posedge core_clk_in);
    #1;
  endtask
  task automatic trig();
    @(posedge core_clk_in);
    trigger_evt_in <= 1'b1;
    @(posedge core_clk_in);
    trigger_evt_in <= 1'b0;
    repeat (ASFM_TRIG_SETTLE_CYC) @(posedge core_clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    u_host.xfer(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  // pop, six data bytes, control read ends the burst
  task automatic burst(input int i, input logic [7:0] c);
    asfm_sample_t s;
    s = smp(i);
    rd(ASFM_OFS_X_LO, 8'h00);
    for (int k = 0; k < 6; k++)
      rd(ASFM_OFS_X_LO + 8'(k), s[32 - 16 * (k / 2) + 8 * (k % 2) +: 8]);
    rd(ASFM_OFS_CTRL, c);
    u_host.close();
  endtask
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("unexpected at %0t: timeout", $time);
      conclude();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    wr(ASFM_OFS_CTRL, 8'h45);
    push(4, 0);
    chk({7'h0, watermark_out}, 8'h00);
    measure_in <= 1'b0;
    push(3, 90);
    measure_in <= 1'b1;
    clk_en_in <= 1'b0;
    push(2, 80);
    clk_en_in <= 1'b1;
    rd(ASFM_OFS_STATUS, 8'h04);
    push(1, 4);
    chk({7'h0, watermark_out}, 8'h01);
    push(29, 5);
    chk({7'h0, overrun_out}, 8'h01);
    rd(ASFM_OFS_STATUS, 8'h20);
    burst(0, 8'h45);
    chk({7'h0, overrun_out}, 8'h00);
    rd(ASFM_OFS_STATUS, 8'h1f);
    rd(ASFM_OFS_X_LO, 8'h00);
    u_host.close();
    burst(2, 8'h45);
    $display("fill test done");
    wr(ASFM_OFS_CTRL, 8'h00);
    rd(ASFM_OFS_STATUS, 8'h00);
    wr(ASFM_OFS_CTRL, 8'h90);
    push(34, 100);
    rd(ASFM_OFS_STATUS, 8'h20);
    burst(102, 8'h90);
    $display("stream test done");
    wr(ASFM_OFS_CTRL, 8'h00);
    wr(ASFM_OFS_CTRL, 8'he4);
    push(10, 200);
    trig();
    chk({6'h0, irq_pin_a_out, irq_pin_b_out}, 8'h01);
    rd(ASFM_OFS_STATUS, 8'h84);
    burst(206, 8'he4);
    chk({7'h0, watermark_out}, 8'h00);
    push(40, 300);
    rd(ASFM_OFS_STATUS, 8'ha0);
    trig();
    rd(ASFM_OFS_STATUS, 8'ha0);
    burst(207, 8'he4);
    wr(ASFM_OFS_CTRL, 8'h00);
    wr(ASFM_OFS_CTRL, 8'hc4);
    trig();
    chk({6'h0, irq_pin_a_out, irq_pin_b_out}, 8'h02);
    rd(8'h10, 8'h00);
    $display("trigger test done");
    conclude();
  end
endmodule // asfm_tb_top
bind asfm_top asfm_checker u_chk (.core_clk_in, .rstn_in, .measure_in,
  .odr_tick_in, .trigger_evt_in, .req_in, .rdata_out, .watermark_out,
  .overrun_out, .irq_pin_a_out, .irq_pin_b_out);
